// File: core/nvmc_pkg.sv
// Package: constants, types and register map of the nonvolatile access control
// Behaviour
// - Space select clear picks EEPROM, set picks flash
// - Config select set targets configuration space
// - Writes need write enable; cleared at power-up
// - Error flag set on enable, cleared on completion
// - Warm reset during a write, or improper write, leaves error flag set
// - Write start set-only; hardware clears on completion
// - Completion sets write-done flag; software clears it
// - Read start reads EEPROM, or configuration space when config select is set; hardware clears it
// - Read start ignored while flash is selected
// - Unlock register has no storage, reads zero
// - EEPROM byte write erases first, then programs
// - Data byte and address byte select access
// - Self-timer, not core clock count, ends writes
// - One register set serves flash and EEPROM
// - Row-erase bit erases table-pointer row, self-clears
package nvmc_pkg;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int CLOCK_PERIOD_NS = 50;
  localparam int PHASE_TIME_US = 2000;
  localparam int PHASE_CYCLES =
    (PHASE_TIME_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // ****************************************************
  // Register indices on the special function port
  // ****************************************************
  localparam logic [3:0] REG_ADDRESS = 4'h0;
  localparam logic [3:0] REG_DATA = 4'h1;
  localparam logic [3:0] REG_CONTROL = 4'h2;
  localparam logic [3:0] REG_UNLOCK = 4'h3;
  localparam logic [3:0] REG_TPTR_UPPER = 4'h4;
  localparam logic [3:0] REG_TPTR_HIGH = 4'h5;
  localparam logic [3:0] REG_TPTR_LOW = 4'h6;
  localparam logic [3:0] REG_TLATCH = 4'h7;
  localparam logic [3:0] REG_FLAGS_TWO = 4'h8;
  localparam logic [3:0] REG_ENABLE_TWO = 4'h9;
  localparam logic [3:0] REG_PRIORITY_TWO = 4'hA;

  // ****************************************************
  // Control/status fields
  // ****************************************************
  localparam int BIT_SPACE = 7;
  localparam int BIT_CONFIG = 6;
  localparam int BIT_ROW_ERASE = 4;
  localparam int BIT_WRITE_ERROR = 3;
  localparam int BIT_WRITE_ENABLE = 2;
  localparam int BIT_WRITE_START = 1;
  localparam int BIT_READ_START = 0;
  localparam int BIT_NVM_DONE = 4;

  localparam logic [7:0] UNLOCK_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] TPTR_UPPER_MASK = 8'h3F;
  localparam logic [7:0] TLATCH_RESET = 8'h00;

  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [1:0] {
    SPACE_EEPROM = 2'h0,
    SPACE_FLASH = 2'h1,
    SPACE_CONFIG = 2'h2
  } nvmc_space_t;

  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_READ = 2'h1,
    OP_ERASE = 2'h2,
    OP_PROGRAM = 2'h3
  } nvmc_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_READ = 3'h1,
    ST_ERASE = 3'h2,
    ST_PROGRAM = 3'h3
  } nvmc_state_t;

  typedef enum logic [1:0] {
    UNL_IDLE = 2'h0,
    UNL_FIRST = 2'h1,
    UNL_ARMED = 2'h2
  } nvmc_unlock_t;

  typedef struct packed {
    logic [3:0] sel;
    logic we;
    logic re;
    logic [7:0] wdata;
  } nvmc_sfr_req_t;

  typedef struct packed {
    nvmc_space_t space;
    nvmc_op_t op;
    logic [21:0] addr;
    logic [7:0] wdata;
  } nvmc_mem_req_t;

endpackage

// File: core/nvmc_self_timer.sv
// Self-timed programming interval counter
`timescale 1ns/100ps
module nvmc_self_timer #(
  parameter int CYCLES = nvmc_pkg::PHASE_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  output logic expired
);

  logic [31:0] count_reg;
  logic running_reg;

  // ****************************************************
  // Interval count
  // ****************************************************
  // Interval set by its own count, independent of core activity
  always_ff @(posedge clock) begin
    if (rst) begin
      count_reg <= 32'h0;
      running_reg <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (start) begin
        count_reg <= 32'(CYCLES - 1);
        running_reg <= 1'b1;
      end else if (running_reg) begin
        if (count_reg == 32'h0) begin
          running_reg <= 1'b0;
          expired <= 1'b1;
        end else begin
          count_reg <= count_reg - 32'h1;
        end
      end
    end
  end

endmodule

// File: core/nvmc_access_ctrl.sv
// Nonvolatile memory access control: registers, unlock and sequencing
`timescale 1ns/100ps
module nvmc_access_ctrl #(
  parameter int PHASE_CYCLES = nvmc_pkg::PHASE_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic por,
  input wire nvmc_pkg::nvmc_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  output nvmc_pkg::nvmc_mem_req_t mem_req,
  output logic mem_strobe,
  input wire logic [7:0] mem_rdata,
  output logic cpu_stall,
  output logic irq_high,
  output logic irq_low
);

  logic any_reset;
  logic [7:0] address_reg;
  logic [7:0] data_reg;
  logic space_reg;
  logic config_reg;
  logic row_erase_reg;
  logic error_reg;
  logic write_enable_bit_reg;
  logic wr_reg;
  logic rd_reg;
  logic [7:0] tptr_upper_reg;
  logic [7:0] tptr_high_reg;
  logic [7:0] tptr_low_reg;
  logic [7:0] tlatch_reg;
  logic [7:0] flags_two_reg;
  logic [7:0] enable_two_reg;
  logic [7:0] priority_two_reg;
  nvmc_pkg::nvmc_state_t state_reg;
  nvmc_pkg::nvmc_unlock_t unlock_reg;
  logic busy;
  logic ctrl_we;
  logic wr_request;
  logic rd_request;
  logic write_go;
  logic write_bad;
  logic read_go;
  logic timer_start;
  logic timer_expired;
  logic write_done;
  nvmc_pkg::nvmc_space_t cur_space;
  logic [7:0] ctrl_image;
  logic [7:0] rdata_next;

  assign any_reset = rst | por;
  assign busy = (state_reg != nvmc_pkg::ST_IDLE);
  assign ctrl_we = sfr_req.we && (sfr_req.sel == nvmc_pkg::REG_CONTROL);
  assign wr_request = ctrl_we && sfr_req.wdata[nvmc_pkg::BIT_WRITE_START]
    && !wr_reg && !busy;
  assign rd_request = ctrl_we && sfr_req.wdata[nvmc_pkg::BIT_READ_START]
    && !rd_reg && !busy;
  // Write proceeds only when enabled and unlocked
  assign write_go = wr_request && write_enable_bit_reg
    && (unlock_reg == nvmc_pkg::UNL_ARMED);
  assign write_bad = wr_request && !write_go;
  // Read refused whenever flash is the selected space
  assign read_go = rd_request && !wr_request
    && !sfr_req.wdata[nvmc_pkg::BIT_SPACE];

  // ****************************************************
  // Space selection
  // ****************************************************
  always_comb begin
    if (config_reg) begin
      cur_space = nvmc_pkg::SPACE_CONFIG;
    end else if (space_reg) begin
      cur_space = nvmc_pkg::SPACE_FLASH;
    end else begin
      cur_space = nvmc_pkg::SPACE_EEPROM;
    end
  end

  // ****************************************************
  // Self-timer
  // ****************************************************
  nvmc_self_timer #(
    .CYCLES(PHASE_CYCLES)
  ) u_timer (
    .clock(clock),
    .rst(any_reset),
    .start(timer_start),
    .expired(timer_expired)
  );

  assign write_done = timer_expired && ((state_reg == nvmc_pkg::ST_PROGRAM)
    || (state_reg == nvmc_pkg::ST_ERASE && row_erase_reg));

  // ****************************************************
  // Sequencer
  // ****************************************************
  always_ff @(posedge clock) begin
    if (any_reset) begin
      state_reg <= nvmc_pkg::ST_IDLE;
      timer_start <= 1'b0;
      mem_strobe <= 1'b0;
      mem_req <= '0;
    end else begin
      timer_start <= 1'b0;
      mem_strobe <= 1'b0;
      case (state_reg)
        nvmc_pkg::ST_IDLE: begin
          if (write_go) begin
            timer_start <= 1'b1;
            mem_strobe <= 1'b1;
            mem_req.space <= cur_space;
            mem_req.wdata <= data_reg;
            if (cur_space == nvmc_pkg::SPACE_EEPROM) begin
              // Byte write always erases its location first
              state_reg <= nvmc_pkg::ST_ERASE;
              mem_req.op <= nvmc_pkg::OP_ERASE;
              mem_req.addr <= {14'h0, address_reg};
            end else if (row_erase_reg) begin
              state_reg <= nvmc_pkg::ST_ERASE;
              mem_req.op <= nvmc_pkg::OP_ERASE;
              mem_req.addr <= {tptr_upper_reg[5:0], tptr_high_reg,
                tptr_low_reg};
            end else begin
              state_reg <= nvmc_pkg::ST_PROGRAM;
              mem_req.op <= nvmc_pkg::OP_PROGRAM;
              mem_req.addr <= {tptr_upper_reg[5:0], tptr_high_reg,
                tptr_low_reg};
              mem_req.wdata <= tlatch_reg;
            end
          end else if (read_go) begin
            state_reg <= nvmc_pkg::ST_READ;
            mem_strobe <= 1'b1;
            mem_req.op <= nvmc_pkg::OP_READ;
            mem_req.space <= sfr_req.wdata[nvmc_pkg::BIT_CONFIG] ?
              nvmc_pkg::SPACE_CONFIG : nvmc_pkg::SPACE_EEPROM;
            mem_req.addr <= {14'h0, address_reg};
          end
        end
        nvmc_pkg::ST_READ: begin
          state_reg <= nvmc_pkg::ST_IDLE;
          mem_req.op <= nvmc_pkg::OP_NONE;
        end
        nvmc_pkg::ST_ERASE: begin
          if (timer_expired) begin
            if (mem_req.space == nvmc_pkg::SPACE_EEPROM) begin
              state_reg <= nvmc_pkg::ST_PROGRAM;
              mem_req.op <= nvmc_pkg::OP_PROGRAM;
              timer_start <= 1'b1;
              mem_strobe <= 1'b1;
            end else begin
              state_reg <= nvmc_pkg::ST_IDLE;
              mem_req.op <= nvmc_pkg::OP_NONE;
            end
          end
        end
        nvmc_pkg::ST_PROGRAM: begin
          if (timer_expired) begin
            state_reg <= nvmc_pkg::ST_IDLE;
            mem_req.op <= nvmc_pkg::OP_NONE;
          end
        end
        default: begin
          state_reg <= nvmc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************
  // Unlock sequence tracking
  // ****************************************************
  // Any other register write breaks the sequence, so stray code
  // cannot leave a half-made unlock waiting
  always_ff @(posedge clock) begin
    if (any_reset) begin
      unlock_reg <= nvmc_pkg::UNL_IDLE;
    end else if (sfr_req.we) begin
      if (sfr_req.sel == nvmc_pkg::REG_UNLOCK) begin
        if (sfr_req.wdata == nvmc_pkg::UNLOCK_FIRST) begin
          unlock_reg <= nvmc_pkg::UNL_FIRST;
        end else if (sfr_req.wdata == nvmc_pkg::UNLOCK_SECOND
                     && unlock_reg == nvmc_pkg::UNL_FIRST) begin
          unlock_reg <= nvmc_pkg::UNL_ARMED;
        end else begin
          unlock_reg <= nvmc_pkg::UNL_IDLE;
        end
      end else begin
        unlock_reg <= nvmc_pkg::UNL_IDLE;
      end
    end
  end

  // ****************************************************
  // Control/status register
  // ****************************************************
  // Space selects survive warm reset; only power-up clears them
  always_ff @(posedge clock) begin
    if (por) begin
      space_reg <= 1'b0;
      config_reg <= 1'b0;
    end else if (ctrl_we && !busy) begin
      space_reg <= sfr_req.wdata[nvmc_pkg::BIT_SPACE];
      config_reg <= sfr_req.wdata[nvmc_pkg::BIT_CONFIG];
    end
  end

  always_ff @(posedge clock) begin
    if (any_reset) begin
      write_enable_bit_reg <= 1'b0;
      row_erase_reg <= 1'b0;
    end else begin
      if (ctrl_we) begin
        write_enable_bit_reg <= sfr_req.wdata[nvmc_pkg::BIT_WRITE_ENABLE];
      end
      if (write_done && row_erase_reg) begin
        row_erase_reg <= 1'b0;
      end else if (ctrl_we && !busy) begin
        row_erase_reg <= sfr_req.wdata[nvmc_pkg::BIT_ROW_ERASE];
      end
    end
  end

  // Warm reset during a write leaves the error flag standing
  always_ff @(posedge clock) begin
    if (por) begin
      error_reg <= 1'b0;
    end else if (rst) begin
      error_reg <= error_reg | busy;
    end else if (write_bad) begin
      error_reg <= 1'b1;
    end else if (ctrl_we && !write_enable_bit_reg
                 && sfr_req.wdata[nvmc_pkg::BIT_WRITE_ENABLE]) begin
      error_reg <= 1'b1;
    end else if (write_done) begin
      error_reg <= 1'b0;
    end else if (ctrl_we) begin
      error_reg <= sfr_req.wdata[nvmc_pkg::BIT_WRITE_ERROR];
    end
  end

  always_ff @(posedge clock) begin
    if (any_reset) begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
    end else begin
      // Software can only set these; hardware clears them
      if (write_go) begin
        wr_reg <= 1'b1;
      end else if (write_done) begin
        wr_reg <= 1'b0;
      end
      if (read_go) begin
        rd_reg <= 1'b1;
      end else if (state_reg == nvmc_pkg::ST_READ) begin
        rd_reg <= 1'b0;
      end
    end
  end

  // ****************************************************
  // Address, data and table registers
  // ****************************************************
  always_ff @(posedge clock) begin
    if (any_reset) begin
      address_reg <= nvmc_pkg::BYTE_ZERO;
      data_reg <= nvmc_pkg::BYTE_ZERO;
    end else begin
      if (sfr_req.we && sfr_req.sel == nvmc_pkg::REG_ADDRESS) begin
        address_reg <= sfr_req.wdata;
      end
      if (state_reg == nvmc_pkg::ST_READ) begin
        data_reg <= mem_rdata;
      end else if (sfr_req.we && sfr_req.sel == nvmc_pkg::REG_DATA
                   && !busy) begin
        data_reg <= sfr_req.wdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (any_reset) begin
      tptr_upper_reg <= nvmc_pkg::BYTE_ZERO;
      tptr_high_reg <= nvmc_pkg::BYTE_ZERO;
      tptr_low_reg <= nvmc_pkg::BYTE_ZERO;
      tlatch_reg <= nvmc_pkg::TLATCH_RESET;
    end else if (sfr_req.we) begin
      if (sfr_req.sel == nvmc_pkg::REG_TPTR_UPPER) begin
        tptr_upper_reg <= sfr_req.wdata & nvmc_pkg::TPTR_UPPER_MASK;
      end else if (sfr_req.sel == nvmc_pkg::REG_TPTR_HIGH) begin
        tptr_high_reg <= sfr_req.wdata;
      end else if (sfr_req.sel == nvmc_pkg::REG_TPTR_LOW) begin
        tptr_low_reg <= sfr_req.wdata;
      end else if (sfr_req.sel == nvmc_pkg::REG_TLATCH) begin
        tlatch_reg <= sfr_req.wdata;
      end
    end
  end

  // ****************************************************
  // Interrupt flag, enable and priority
  // ****************************************************
  always_ff @(posedge clock) begin
    if (any_reset) begin
      flags_two_reg <= nvmc_pkg::BYTE_ZERO;
      enable_two_reg <= nvmc_pkg::BYTE_ZERO;
      priority_two_reg <= nvmc_pkg::BYTE_ZERO;
    end else begin
      if (sfr_req.we && sfr_req.sel == nvmc_pkg::REG_FLAGS_TWO) begin
        flags_two_reg <= sfr_req.wdata;
      end
      // Completion beats a clear in the same cycle
      if (write_done) begin
        flags_two_reg[nvmc_pkg::BIT_NVM_DONE] <= 1'b1;
      end
      if (sfr_req.we && sfr_req.sel == nvmc_pkg::REG_ENABLE_TWO) begin
        enable_two_reg <= sfr_req.wdata;
      end
      if (sfr_req.we && sfr_req.sel == nvmc_pkg::REG_PRIORITY_TWO) begin
        priority_two_reg <= sfr_req.wdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (any_reset) begin
      irq_high <= 1'b0;
      irq_low <= 1'b0;
      cpu_stall <= 1'b0;
    end else begin
      irq_high <= flags_two_reg[nvmc_pkg::BIT_NVM_DONE]
        && enable_two_reg[nvmc_pkg::BIT_NVM_DONE]
        && priority_two_reg[nvmc_pkg::BIT_NVM_DONE];
      irq_low <= flags_two_reg[nvmc_pkg::BIT_NVM_DONE]
        && enable_two_reg[nvmc_pkg::BIT_NVM_DONE]
        && !priority_two_reg[nvmc_pkg::BIT_NVM_DONE];
      // Core halts while flash or configuration is programmed
      cpu_stall <= (write_go && cur_space != nvmc_pkg::SPACE_EEPROM)
        || (cpu_stall && busy && !write_done);
    end
  end

  // ****************************************************
  // Read-back
  // ****************************************************
  always_comb begin
    ctrl_image = nvmc_pkg::BYTE_ZERO;
    ctrl_image[nvmc_pkg::BIT_SPACE] = space_reg;
    ctrl_image[nvmc_pkg::BIT_CONFIG] = config_reg;
    ctrl_image[nvmc_pkg::BIT_ROW_ERASE] = row_erase_reg;
    ctrl_image[nvmc_pkg::BIT_WRITE_ERROR] = error_reg;
    ctrl_image[nvmc_pkg::BIT_WRITE_ENABLE] = write_enable_bit_reg;
    ctrl_image[nvmc_pkg::BIT_WRITE_START] = wr_reg;
    ctrl_image[nvmc_pkg::BIT_READ_START] = rd_reg;
  end

  always_comb begin
    if (sfr_req.sel == nvmc_pkg::REG_ADDRESS) begin
      rdata_next = address_reg;
    end else if (sfr_req.sel == nvmc_pkg::REG_DATA) begin
      rdata_next = data_reg;
    end else if (sfr_req.sel == nvmc_pkg::REG_CONTROL) begin
      rdata_next = ctrl_image;
    end else if (sfr_req.sel == nvmc_pkg::REG_UNLOCK) begin
      rdata_next = nvmc_pkg::BYTE_ZERO;
    end else if (sfr_req.sel == nvmc_pkg::REG_TPTR_UPPER) begin
      rdata_next = tptr_upper_reg;
    end else if (sfr_req.sel == nvmc_pkg::REG_TPTR_HIGH) begin
      rdata_next = tptr_high_reg;
    end else if (sfr_req.sel == nvmc_pkg::REG_TPTR_LOW) begin
      rdata_next = tptr_low_reg;
    end else if (sfr_req.sel == nvmc_pkg::REG_TLATCH) begin
      rdata_next = tlatch_reg;
    end else if (sfr_req.sel == nvmc_pkg::REG_FLAGS_TWO) begin
      rdata_next = flags_two_reg;
    end else if (sfr_req.sel == nvmc_pkg::REG_ENABLE_TWO) begin
      rdata_next = enable_two_reg;
    end else if (sfr_req.sel == nvmc_pkg::REG_PRIORITY_TWO) begin
      rdata_next = priority_two_reg;
    end else begin
      rdata_next = nvmc_pkg::BYTE_ZERO;
    end
  end

  always_ff @(posedge clock) begin
    if (any_reset) begin
      sfr_rdata <= nvmc_pkg::BYTE_ZERO;
    end else if (sfr_req.re) begin
      sfr_rdata <= rdata_next;
    end
  end

endmodule

// File: verif/nvmc_access_ctrl_assertions.sv
// Port checker for the nonvolatile access control
`timescale 1ns/100ps
module nvmc_access_ctrl_assertions #(
  parameter int PHASE_CYCLES = nvmc_pkg::PHASE_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic por,
  input wire nvmc_pkg::nvmc_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire nvmc_pkg::nvmc_mem_req_t mem_req,
  input wire logic mem_strobe,
  input wire logic [7:0] mem_rdata,
  input wire logic cpu_stall,
  input wire logic irq_high,
  input wire logic irq_low
);
  // ****************************************************
  // Helpers
  // ****************************************************
  localparam int MAX_GAP = 2 * PHASE_CYCLES + 4;
  logic ctl_wr;
  assign ctl_wr = sfr_req.we && sfr_req.sel == nvmc_pkg::REG_CONTROL;
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst || por);
  sequence ee_erase;
    mem_strobe && mem_req.op == nvmc_pkg::OP_ERASE
      && mem_req.space == nvmc_pkg::SPACE_EEPROM;
  endsequence
  sequence ee_program;
    mem_strobe && mem_req.op == nvmc_pkg::OP_PROGRAM
      && mem_req.space == nvmc_pkg::SPACE_EEPROM;
  endsequence
  // ****************************************************
  // Assertions
  // ****************************************************
  unlock_reads_zero_a: assert property (
    sfr_req.re && sfr_req.sel == nvmc_pkg::REG_UNLOCK
      |=> sfr_rdata == nvmc_pkg::BYTE_ZERO)
    else $error("unlock register read back nonzero");
  flash_read_refused_a: assert property (
    ctl_wr && sfr_req.wdata[nvmc_pkg::BIT_SPACE]
      |=> !(mem_strobe && mem_req.op == nvmc_pkg::OP_READ))
    else $error("read started with flash selected");
  erase_then_program_a: assert property (
    ee_erase |-> ##[1:MAX_GAP] ee_program)
    else $error("byte erase not followed by program");
  phase_length_a: assert property (
    mem_strobe && mem_req.op != nvmc_pkg::OP_READ |=> !mem_strobe [*8])
    else $error("programming phase ended too early");
  stall_space_a: assert property (
    cpu_stall |-> mem_req.space != nvmc_pkg::SPACE_EEPROM)
    else $error("core stalled on a data byte write");
  byte_address_a: assert property (
    mem_strobe && mem_req.space == nvmc_pkg::SPACE_EEPROM
      |-> mem_req.addr[21:8] == 14'h0000)
    else $error("byte address wider than address register");
  irq_exclusive_a: assert property (
    !(irq_high && irq_low))
    else $error("both interrupt levels requested");
  reset_quiet_a: assert property (disable iff (1'b0)
    por |=> !mem_strobe && !cpu_stall && !irq_high && !irq_low
      && mem_req.op == nvmc_pkg::OP_NONE)
    else $error("outputs active after power-on reset");
endmodule
bind nvmc_access_ctrl nvmc_access_ctrl_assertions #(
  .PHASE_CYCLES(PHASE_CYCLES)
) i_nvmc_access_ctrl_assertions (
  .clock(clock),
  .rst(rst),
  .por(por),
  .sfr_req(sfr_req),
  .sfr_rdata(sfr_rdata),
  .mem_req(mem_req),
  .mem_strobe(mem_strobe),
  .mem_rdata(mem_rdata),
  .cpu_stall(cpu_stall),
  .irq_high(irq_high),
  .irq_low(irq_low)
);

// File: verif/nvmc_mem_model.sv
// Behavioural model of the data byte array
`timescale 1ns/100ps
module nvmc_mem_model (
  input wire logic clock,
  input wire nvmc_pkg::nvmc_mem_req_t mem_req,
  input wire logic mem_strobe,
  output logic [7:0] mem_rdata
);
  logic [7:0] eeprom [256];
  nvmc_pkg::nvmc_space_t last_space;
  nvmc_pkg::nvmc_op_t last_op;
  logic [7:0] idle_pattern;
  initial begin
    for (int i = 0; i < 256; i++) begin
      eeprom[i] = 8'hFF;
    end
    last_space = nvmc_pkg::SPACE_EEPROM;
    last_op = nvmc_pkg::OP_NONE;
    idle_pattern = 8'h3C;
  end
  always @(posedge clock) begin
    idle_pattern <= ~idle_pattern;
    if (mem_strobe) begin
      last_space <= mem_req.space;
      last_op <= mem_req.op;
      if (mem_req.space == nvmc_pkg::SPACE_EEPROM) begin
        if (mem_req.op == nvmc_pkg::OP_ERASE) begin
          eeprom[mem_req.addr[7:0]] <= 8'hFF;
        end
        if (mem_req.op == nvmc_pkg::OP_PROGRAM) begin
          eeprom[mem_req.addr[7:0]] <= mem_req.wdata;
        end
      end
    end
  end
  // Toggling value outside reads exposes a late sample
  assign mem_rdata = (mem_req.op == nvmc_pkg::OP_READ) ?
    eeprom[mem_req.addr[7:0]] : idle_pattern;
endmodule

// File: verif/nvmc_access_ctrl_tb.sv
// Self-checking testbench of the nonvolatile access control
`timescale 1ns/100ps
module nvmc_access_ctrl_tb;
  localparam int PHASES = 8;
  logic clock;
  logic rst;
  logic por;
  nvmc_pkg::nvmc_sfr_req_t sfr_req;
  logic [7:0] sfr_rdata;
  nvmc_pkg::nvmc_mem_req_t mem_req;
  logic mem_strobe;
  logic [7:0] mem_rdata;
  logic cpu_stall;
  logic irq_high;
  logic irq_low;
  int num_errors;
  int compares;
  int cycles;
  logic [7:0] val;
  nvmc_access_ctrl #(.PHASE_CYCLES(PHASES)) i_nvmc_access_ctrl (
    .clock(clock), .rst(rst), .por(por), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .mem_req(mem_req), .mem_strobe(mem_strobe),
    .mem_rdata(mem_rdata), .cpu_stall(cpu_stall), .irq_high(irq_high),
    .irq_low(irq_low));
  nvmc_mem_model i_nvmc_mem_model (.clock(clock), .mem_req(mem_req),
    .mem_strobe(mem_strobe), .mem_rdata(mem_rdata));
  // ****************************************************
  // Shared tasks
  // ****************************************************
  task automatic stop_test;
    if (num_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] sel, input logic [7:0] d);
    @(negedge clock);
    sfr_req = '{sel: sel, we: 1'b1, re: 1'b0, wdata: d};
    @(negedge clock);
    sfr_req.we = 1'b0;
  endtask
  task automatic rd(input logic [3:0] sel);
    @(negedge clock);
    sfr_req = '{sel: sel, we: 1'b0, re: 1'b1, wdata: 8'h00};
    @(negedge clock);
    sfr_req.re = 1'b0;
    val = sfr_rdata;
  endtask
  task automatic rdc(input logic [3:0] sel, input logic [7:0] exp);
    rd(sel);
    check(val, exp);
  endtask
  // Unlock must immediately precede the starting control write
  task automatic unlock_go(input logic [7:0] ctl);
    wr(nvmc_pkg::REG_UNLOCK, nvmc_pkg::UNLOCK_FIRST);
    wr(nvmc_pkg::REG_UNLOCK, nvmc_pkg::UNLOCK_SECOND);
    wr(nvmc_pkg::REG_CONTROL, ctl);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      rd(nvmc_pkg::REG_CONTROL);
      n++;
    end while (val[1] !== 1'b0 && n < 60);
    check({7'h00, val[1]}, 8'h00);
  endtask
  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic t_power_on;
    rdc(nvmc_pkg::REG_CONTROL, 8'h00);
    wr(nvmc_pkg::REG_UNLOCK, 8'h55);
    rdc(nvmc_pkg::REG_UNLOCK, 8'h00);
    rdc(4'hF, 8'h00);
  endtask
  task automatic t_byte_write;
    wr(nvmc_pkg::REG_ADDRESS, 8'h12);
    wr(nvmc_pkg::REG_DATA, 8'hA5);
    wr(nvmc_pkg::REG_CONTROL, 8'h04);
    rdc(nvmc_pkg::REG_CONTROL, 8'h0C);
    // Error bit kept in the starting write, as a bit-set would
    unlock_go(8'h0E);
    check({7'h00, cpu_stall}, 8'h00);
    rdc(nvmc_pkg::REG_CONTROL, 8'h0E);
    wr(nvmc_pkg::REG_CONTROL, 8'h0C);
    rdc(nvmc_pkg::REG_CONTROL, 8'h0E);
    wait_idle();
    check(val, 8'h04);
    rdc(nvmc_pkg::REG_FLAGS_TWO, 8'h10);
    check(i_nvmc_mem_model.eeprom[8'h12], 8'hA5);
  endtask
  task automatic t_reads;
    wr(nvmc_pkg::REG_DATA, 8'h00);
    wr(nvmc_pkg::REG_CONTROL, 8'h01);
    repeat (3) @(negedge clock);
    rdc(nvmc_pkg::REG_DATA, 8'hA5);
    rdc(nvmc_pkg::REG_CONTROL, 8'h00);
    wr(nvmc_pkg::REG_CONTROL, 8'h41);
    repeat (3) @(negedge clock);
    check({6'h00, i_nvmc_mem_model.last_space}, 8'h02);
    wr(nvmc_pkg::REG_DATA, 8'h00);
    wr(nvmc_pkg::REG_CONTROL, 8'h81);
    repeat (3) @(negedge clock);
    rdc(nvmc_pkg::REG_DATA, 8'h00);
    rdc(nvmc_pkg::REG_CONTROL, 8'h80);
  endtask
  task automatic t_improper;
    wr(nvmc_pkg::REG_CONTROL, 8'h04);
    wr(nvmc_pkg::REG_CONTROL, 8'h04);
    rdc(nvmc_pkg::REG_CONTROL, 8'h04);
    wr(nvmc_pkg::REG_CONTROL, 8'h06);
    rdc(nvmc_pkg::REG_CONTROL, 8'h0C);
  endtask
  task automatic t_spaces;
    logic [7:0] ctl [3] = '{8'h84, 8'h94, 8'h44};
    logic [1:0] op [3] = '{2'h3, 2'h2, 2'h3};
    logic [1:0] sp [3] = '{2'h1, 2'h1, 2'h2};
    for (int i = 0; i < 3; i++) begin
      wr(nvmc_pkg::REG_CONTROL, ctl[i]);
      unlock_go(ctl[i] | 8'h02);
      // Model latches the strobe one edge later
      @(negedge clock);
      check({7'h00, cpu_stall}, 8'h01);
      check({6'h00, i_nvmc_mem_model.last_op}, {6'h00, op[i]});
      check({6'h00, i_nvmc_mem_model.last_space}, {6'h00, sp[i]});
      wait_idle();
      check(val, ctl[i] & 8'hEF);
    end
  endtask
  task automatic t_irq;
    wr(nvmc_pkg::REG_ENABLE_TWO, 8'h10);
    wr(nvmc_pkg::REG_PRIORITY_TWO, 8'h10);
    @(negedge clock);
    check({6'h00, irq_high, irq_low}, 8'h02);
    wr(nvmc_pkg::REG_PRIORITY_TWO, 8'h00);
    @(negedge clock);
    check({6'h00, irq_high, irq_low}, 8'h01);
    wr(nvmc_pkg::REG_FLAGS_TWO, 8'h00);
    @(negedge clock);
    check({6'h00, irq_high, irq_low}, 8'h00);
  endtask
  task automatic t_warm_reset;
    wr(nvmc_pkg::REG_CONTROL, 8'h84);
    unlock_go(8'h86);
    repeat (3) @(negedge clock);
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    rd(nvmc_pkg::REG_CONTROL);
    check(val & 8'hC8, 8'h88);
  endtask
  // ****************************************************
  // Clock, timeout and main sequence
  // ****************************************************
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    por = 1'b1;
    rst = 1'b0;
    sfr_req = '0;
    num_errors = 0;
    compares = 0;
    cycles = 0;
    repeat (10) @(negedge clock);
    por = 1'b0;
    t_power_on();
    t_byte_write();
    t_reads();
    t_improper();
    t_spaces();
    t_irq();
    t_warm_reset();
    stop_test();
  end
endmodule
